// ===== shared/pdmirq_defs.svh
// Register offsets, field positions and reset values of the event and interrupt-enable block.
`ifndef PDMIRQ_DEFS_SVH
`define PDMIRQ_DEFS_SVH
`define PDMIRQ_ADDR_W      12
`define PDMIRQ_OFS_BEGUN   12'h100
`define PDMIRQ_OFS_FINISH  12'h104
`define PDMIRQ_OFS_BUFDONE 12'h108
`define PDMIRQ_OFS_MASK    12'h300
`define PDMIRQ_OFS_SET     12'h304
`define PDMIRQ_OFS_CLR     12'h308
`define PDMIRQ_BIT_BEGUN   0
`define PDMIRQ_BIT_FINISH  1
`define PDMIRQ_BIT_BUFDONE 2
`define PDMIRQ_BIT_FLAG    0
`define PDMIRQ_FLAG_RST    1'h0
`define PDMIRQ_MASK_RST    3'h0
`endif

// ===== shared/pdmirq_pkg.sv
// Types shared by the event and interrupt-enable block.
package pdmirq_pkg;
   typedef struct packed {
      logic        wr;
      logic        rd;
      logic [11:0] addr;
      logic [31:0] wdata;
   } pdmirq_bus_s;
   typedef struct packed {
      logic begun;
      logic finished;
      logic buf_done;
   } pdmirq_evt_s;
endpackage

// ===== core/pdmirq_logic.sv
// Event flags, interrupt enable mask with set/clear aliases and interrupt request.
//
// The address-and-strobe port was left to the implementer.
`timescale 1ns/1ps
`include "pdmirq_defs.svh"

// Function
// RL1: Finished event sets transfer finished flag.
// RL2: Last sample stored sets buffer done flag.
// RL3: Early halt's last sample sets buffer done.
// RL4: Transfer start sets transfer begun flag.
// RL5: Read-write mask, one enable bit per event.
// RL6: Set alias enables ones; reads mask.
// RL7: Clear alias disables ones; reads mask.
// RL8: Software writes flags; zero clears them.
// RL9: Request when enabled flag set; zero writes inert.
module pdmirq_logic (
   // Clock and reset
   input  wire logic                      mclk,
   input  wire logic                      rst_n,
   // Register port
   input  wire pdmirq_pkg::pdmirq_bus_s   bus,
   output logic        [31:0]             rdata,
   // Receiver core event pulses
   input  wire pdmirq_pkg::pdmirq_evt_s   evt,
   // Interrupt request
   output logic                           irq
);

   // ****************************************************************
   // Address decode
   // ****************************************************************
   // Offsets are compared in full, so any unmapped offset hits nothing and is ignored.
   function automatic logic ofs_hit(input logic [11:0] a, input logic [11:0] ofs);
      ofs_hit = (a == ofs);
   endfunction

   wire hit_begun   = ofs_hit(bus.addr, `PDMIRQ_OFS_BEGUN);
   wire hit_finish  = ofs_hit(bus.addr, `PDMIRQ_OFS_FINISH);
   wire hit_bufdone = ofs_hit(bus.addr, `PDMIRQ_OFS_BUFDONE);
   wire hit_mask    = ofs_hit(bus.addr, `PDMIRQ_OFS_MASK);
   wire hit_set     = ofs_hit(bus.addr, `PDMIRQ_OFS_SET);
   wire hit_clr     = ofs_hit(bus.addr, `PDMIRQ_OFS_CLR);

   wire wr_begun   = bus.wr && hit_begun;
   wire wr_finish  = bus.wr && hit_finish;
   wire wr_bufdone = bus.wr && hit_bufdone;
   wire wr_mask    = bus.wr && hit_mask;
   wire wr_set     = bus.wr && hit_set;
   wire wr_clr     = bus.wr && hit_clr;

   // Only bit zero of a flag word carries state; the upper bits are ignored.
   wire wflag = bus.wdata[`PDMIRQ_BIT_FLAG];

   logic       flag_begun;
   logic       flag_finish;
   logic       flag_bufdone;
   logic [2:0] mask;

   // ****************************************************************
   // Event flags
   // ****************************************************************
   // A hardware event in the same cycle as a software write wins, so no event is lost.
   function automatic logic flag_next(input logic cur, input logic ev, input logic we,
                                      input logic wbit);
      flag_next = ev ? 1'b1 : (we ? wbit : cur);
   endfunction

   wire next_begun   = flag_next(flag_begun, evt.begun, wr_begun, wflag); // [RL4] [RL8]
   wire next_finish  = flag_next(flag_finish, evt.finished, wr_finish,
                                 wflag); // [RL1] [RL8]
   // The core pulses buf_done both at the sample limit and after an early halt.
   wire next_bufdone = flag_next(flag_bufdone, evt.buf_done, wr_bufdone,
                                 wflag); // [RL2] [RL3] [RL8]

   // ****************************************************************
   // Enable mask
   // ****************************************************************
   // A full mask write takes priority over the aliases; only one can hit per cycle anyway.
   wire [2:0] wbits = bus.wdata[`PDMIRQ_BIT_BUFDONE:`PDMIRQ_BIT_BEGUN];
   wire [2:0] next_mask = wr_mask ? wbits :                  // [RL5]
                          wr_set  ? (mask | wbits) :         // [RL6] [RL9]
                          wr_clr  ? (mask & ~wbits) : mask;  // [RL7] [RL9]

   wire [2:0] flags = {flag_bufdone, flag_finish, flag_begun};
   // The request is built from next values so that it moves in the same cycle as the flags.
   wire next_irq = |(next_mask & {next_bufdone, next_finish, next_begun}); // [RL9]

   // ****************************************************************
   // Read mux
   // ****************************************************************
   // All three mask offsets read back the same mask word.
   wire rd_mask = hit_mask || hit_set || hit_clr;
   // Read data fall back to zero outside a read, so stale words never linger on the port.
   wire [31:0] next_rdata =
      !bus.rd      ? 32'h0000_0000 :
      hit_begun    ? {31'h0, flag_begun} :
      hit_finish   ? {31'h0, flag_finish} :
      hit_bufdone  ? {31'h0, flag_bufdone} :
      rd_mask      ? {29'h0, mask} : 32'h0000_0000; // [RL6] [RL7]

   // ****************************************************************
   // Registers
   // ****************************************************************
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         flag_begun   <= `PDMIRQ_FLAG_RST;
         flag_finish  <= `PDMIRQ_FLAG_RST;
         flag_bufdone <= `PDMIRQ_FLAG_RST;
      end else begin
         flag_begun   <= next_begun;
         flag_finish  <= next_finish;
         flag_bufdone <= next_bufdone;
      end
   end

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         mask <= `PDMIRQ_MASK_RST;
      end else begin
         mask <= next_mask;
      end
   end

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         irq <= 1'b0;
      end else begin
         irq <= next_irq;
      end
   end

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         rdata <= 32'h0000_0000;
      end else begin
         rdata <= next_rdata;
      end
   end

   // ****************************************************************
   // Assertions
   // ****************************************************************
   finish_sets_a: assert property (@(posedge mclk) disable iff (!rst_n)
      evt.finished |=> flag_finish) else $error("finished flag not set"); // [RL1]
   bufdone_sets_a: assert property (@(posedge mclk) disable iff (!rst_n)
      evt.buf_done |=> flag_bufdone) else $error("buffer done flag not set"); // [RL2]
   bufdone_holds_a: assert property (@(posedge mclk) disable iff (!rst_n)
      evt.buf_done ##1 !(evt.buf_done || wr_bufdone) |=> flag_bufdone)
      else $error("buffer done flag lost"); // [RL3]
   begun_sets_a: assert property (@(posedge mclk) disable iff (!rst_n)
      evt.begun |=> flag_begun) else $error("begun flag not set"); // [RL4]
   mask_write_a: assert property (@(posedge mclk) disable iff (!rst_n)
      wr_mask |=> mask == $past(bus.wdata[2:0])) else $error("mask write wrong"); // [RL5]
   set_alias_a: assert property (@(posedge mclk) disable iff (!rst_n)
      wr_set |=> (mask & $past(bus.wdata[2:0])) == $past(bus.wdata[2:0]))
      else $error("set alias failed"); // [RL6]
   clr_alias_a: assert property (@(posedge mclk) disable iff (!rst_n)
      wr_clr |=> (mask & $past(bus.wdata[2:0])) == 3'h0) else $error("clear alias failed"); // [RL7]
   flag_clear_a: assert property (@(posedge mclk) disable iff (!rst_n)
      wr_finish && !bus.wdata[0] && !evt.finished |=> !flag_finish)
      else $error("flag clear failed"); // [RL8]
   irq_level_a: assert property (@(posedge mclk) disable iff (!rst_n)
      irq == |(mask & flags)) else $error("irq mismatch"); // [RL9]
   alias_read_a: assert property (@(posedge mclk) disable iff (!rst_n)
      bus.rd && rd_mask |=> rdata[2:0] == $past(mask)) else $error("alias read wrong"); // [RL6]
   rdata_idle_a: assert property (@(posedge mclk) disable iff (!rst_n)
      !bus.rd |=> rdata == 32'h0000_0000) else $error("read data not idle"); // [RL5]
   rdata_upper_a: assert property (@(posedge mclk) disable iff (!rst_n)
      rdata[31:3] == 29'h0) else $error("read data upper bits set"); // [RL5]
   event_wins_a: assert property (@(posedge mclk) disable iff (!rst_n)
      evt.finished && wr_finish |=> flag_finish) else $error("event lost to write"); // [RL1]
   begun_write_a: assert property (@(posedge mclk) disable iff (!rst_n)
      wr_begun && !wflag && !evt.begun |=> !flag_begun) else $error("begun clear failed"); // [RL8]
   bufdone_clear_a: assert property (@(posedge mclk) disable iff (!rst_n)
      wr_bufdone && !wflag && !evt.buf_done |=> !flag_bufdone)
      else $error("buffer done clear failed"); // [RL8]
   set_exact_a: assert property (@(posedge mclk) disable iff (!rst_n)
      wr_set |=> mask == ($past(mask) | $past(bus.wdata[2:0])))
      else $error("set alias disturbed mask"); // [RL9]
   clr_exact_a: assert property (@(posedge mclk) disable iff (!rst_n)
      wr_clr |=> mask == ($past(mask) & ~$past(bus.wdata[2:0])))
      else $error("clear alias disturbed mask"); // [RL9]
   mask_hold_a: assert property (@(posedge mclk) disable iff (!rst_n)
      !(wr_mask || wr_set || wr_clr) |=> $stable(mask)) else $error("mask changed"); // [RL5]
   finish_read_a: assert property (@(posedge mclk) disable iff (!rst_n)
      bus.rd && hit_finish |=> rdata[0] == $past(flag_finish))
      else $error("finished read wrong"); // [RL1]

endmodule // pdmirq_logic

// ===== test/pdmirq_logic_test.sv
// Register-level testbench for the event flag and interrupt-enable block.
`timescale 1ns/1ps
`include "pdmirq_defs.svh"
`define CHK(a, e) begin num_checks++; if ((a) !== (e)) begin failures++; \
   $display("Error at %0t: got %h expected %h", $time, a, e); end end
module pdmirq_logic_test;
   logic                    mclk = 1'b0;
   logic                    rst_n = 1'b0;
   pdmirq_pkg::pdmirq_bus_s bus = '0;
   pdmirq_pkg::pdmirq_evt_s evt = '0;
   logic [31:0]             rdata;
   logic                    irq;
   int                      failures = 0;
   int                      num_checks = 0;
   logic [11:0]             ofs [7] = '{12'h100, 12'h104, 12'h108, 12'h300, 12'h304, 12'h308, 12'h0FC};
   always #12.5 mclk = ~mclk;
   pdmirq_logic i_pdmirq_logic (.mclk(mclk), .rst_n(rst_n), .bus(bus), .rdata(rdata),
                                .evt(evt), .irq(irq));
   // ***********************************************************************
   // Bus and event tasks
   // ***********************************************************************
   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      @(posedge mclk); bus.wr <= 1'b1; bus.addr <= a; bus.wdata <= d;
      @(posedge mclk); bus.wr <= 1'b0; #1;
   endtask
   // Read data stand only in the cycle after the strobe, so they are taken there.
   task automatic rd(input logic [11:0] a, input logic [31:0] e);
      @(posedge mclk); bus.rd <= 1'b1; bus.addr <= a;
      @(posedge mclk); bus.rd <= 1'b0; #1;
      `CHK(rdata, e)
   endtask
   task automatic pulse(input logic [2:0] v);
      @(posedge mclk); evt <= v;
      @(posedge mclk); evt <= '0; #1;
   endtask
   task automatic wrap_up();
      $display("Checks %0d, mismatches %0d", num_checks, failures);
      if (failures == 0 && num_checks > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask
   initial begin
      #100000; failures++; wrap_up();
   end
   initial begin
      repeat (5) @(posedge mclk);
      rst_n <= 1'b1;
      foreach (ofs[i]) rd(ofs[i], 32'h0);
      wr(`PDMIRQ_OFS_MASK, 32'hFFFFFFF5);
      rd(`PDMIRQ_OFS_MASK, 32'h5);
      wr(`PDMIRQ_OFS_CLR, 32'h1);
      rd(`PDMIRQ_OFS_SET, 32'h4);
      wr(`PDMIRQ_OFS_SET, 32'h0);
      wr(`PDMIRQ_OFS_CLR, 32'h0);
      rd(`PDMIRQ_OFS_MASK, 32'h4);
      wr(`PDMIRQ_OFS_SET, 32'h2);
      rd(`PDMIRQ_OFS_CLR, 32'h6);
      `CHK(irq, 1'b0)
      pulse(3'b010);
      `CHK(irq, 1'b1)
      rd(`PDMIRQ_OFS_FINISH, 32'h1);
      wr(`PDMIRQ_OFS_FINISH, 32'h0);
      `CHK(irq, 1'b0)
      rd(`PDMIRQ_OFS_FINISH, 32'h0);
      pulse(3'b001);
      `CHK(irq, 1'b1)
      rd(`PDMIRQ_OFS_BUFDONE, 32'h1);
      wr(`PDMIRQ_OFS_CLR, 32'h4);
      `CHK(irq, 1'b0)
      wr(12'h10C, 32'h0);
      rd(`PDMIRQ_OFS_BUFDONE, 32'h1);
      pulse(3'b100);
      `CHK(irq, 1'b0)
      rd(`PDMIRQ_OFS_BEGUN, 32'h1);
      wr(`PDMIRQ_OFS_FINISH, 32'h1);
      `CHK(irq, 1'b1)
      rd(`PDMIRQ_OFS_MASK, 32'h2);
      // An event in the same cycle as a clearing write must win.
      @(posedge mclk); bus.wr <= 1'b1; bus.addr <= `PDMIRQ_OFS_FINISH; bus.wdata <= 32'h0;
      evt <= 3'b010;
      @(posedge mclk); bus.wr <= 1'b0; evt <= '0; #1;
      `CHK(irq, 1'b1)
      rd(`PDMIRQ_OFS_FINISH, 32'h1);
      // A reset in mid-run returns the finished and begun flags, the mask and the request to zero.
      @(posedge mclk); rst_n <= 1'b0;
      @(posedge mclk); #1;
      `CHK(irq, 1'b0)
      repeat (2) @(posedge mclk);
      rst_n <= 1'b1;
      rd(`PDMIRQ_OFS_FINISH, 32'h0);
      rd(`PDMIRQ_OFS_BEGUN, 32'h0);
      rd(`PDMIRQ_OFS_MASK, 32'h0);
      wrap_up();
   end
endmodule // pdmirq_logic_test
